// ==== design/bscan_pkg.sv ====
// Behaviour
// - Test reset flag (status bit 4) sets when the reset register's one forces reset.
// - Flag clears only by power-on reset or software writing zero to it.
// - Each bidirectional pin cell merges control, data and input into two stages.
// - Each pin also has a separate standard cell for its pull-up enable.
// - Scanned input data is the pin level, taken through the two flop synchroniser.
// - Scanned output data follows port bit; scanned control follows direction bit.
// - Scanned pull-up enable is pull-up-allowed AND input-direction AND port bit.
// - Alternate functions sit outside the cell, so capture sees the real pin level.
// - Analog pins go direct; cells sit on digital-to-analog boundary signals.
// - Observe-only cells watch the normal reset and high-voltage reset detections.
// - Each external oscillator: general cell on enable, observe cell on clock.
// - Timer oscillator is scanned the same way as the main clock sources.
// - Internal RC oscillator output is not in the chain.
// - Four enable/clock pairs are scanned; an unused clock line reads zero.
// - Internal load capacitor selection has no cell; fuses alone decide it.
// - Comparator idle, output and bandgap enable each have a scan cell.
// - With idle one and bandgap zero, scanned comparator output reads zero.
// - All scan registers shift least significant bit first, in and out.
// - Comparator boundary cells take the most significant chain positions.
// - The four test access pins have no cells in the chain.
package bscan_pkg;

    // Chain geometry
    localparam int CHAIN_LEN      = 106;
    localparam int NUM_PINS       = 31;
    localparam int PIN_PULLUP_OFS = 0;
    localparam int PIN_CTRL_OFS   = 1;
    localparam int PIN_DATA_OFS   = 2;

    // Fixed cell positions
    localparam int POS_CMP_IDLE   = 105;
    localparam int POS_CMP_OUT    = 104;
    localparam int POS_BG_EN      = 103;
    localparam int POS_RST_NORMAL = 78;
    localparam int POS_RST_HV     = 77;
    localparam int POS_TIMER_CK   = 76;
    localparam int POS_TIMER_EN   = 75;
    localparam int POS_EXT_EN     = 50;
    localparam int POS_OSC_EN     = 49;
    localparam int POS_LF_EN      = 48;
    localparam int POS_EXT_CK     = 47;
    localparam int POS_OSC_CK     = 46;
    localparam int POS_LF_CK      = 45;

    // Base position of each pin triple, pin index 0 first
    localparam int PIN_BASE [NUM_PINS] = '{
        0, 3, 6, 9, 12, 15, 18, 21,
        24, 27, 30,
        33, 36, 39, 42,
        51, 54, 57, 60, 63, 66, 69, 72,
        79, 82, 85, 88, 91, 94, 97, 100};

    // Register port
    localparam int             ADDR_W          = 8;
    localparam logic [7:0]     STATUS_ADDR     = 8'h34;
    localparam int             TEST_RESET_BIT  = 4;
    localparam logic [7:0]     STATUS_RESET    = 8'h00;
    localparam logic [7:0]     READ_UNMAPPED   = 8'h00;

    // System clock
    localparam int CLK_PERIOD_PS = 5000;

    // Scan controller state lines
    typedef struct packed {
        logic capture;
        logic shift;
        logic update;
        logic extest;
        logic sample;
        logic force_reset;
    } tap_ctl_t;

    // One bit per scanned clock source
    typedef struct packed {
        logic ext;
        logic osc;
        logic lf;
        logic timer;
    } clk_ctl_t;

    // Comparator boundary inputs
    typedef struct packed {
        logic idle;
        logic bandgap;
    } cmp_ctl_t;

    // Every input that arrives from outside the clock domain
    typedef struct packed {
        logic [NUM_PINS-1:0] pin_in;
        logic                tck;
        logic                tdi;
        tap_ctl_t            tap;
        logic                normal_reset_n;
        logic                hv_reset;
        clk_ctl_t            clk_line;
        logic                cmp_out;
        logic                power_on;
    } async_in_t;

    // Top module state
    typedef struct packed {
        logic                 tck_prev;
        logic [CHAIN_LEN-1:0] chain;
        logic [CHAIN_LEN-1:0] upd;
        logic                 reset_bit;
        logic                 tdo;
        logic [NUM_PINS-1:0]  pin_out;
        logic [NUM_PINS-1:0]  pin_oe_n;
        logic [NUM_PINS-1:0]  pin_pu;
        clk_ctl_t             osc_en;
        cmp_ctl_t             cmp;
        logic                 test_reset;
        logic [7:0]           rdata;
    } scan_state_t;

    // Pin triple base lookup
    function automatic int pin_base(input int idx);
        return PIN_BASE[idx];
    endfunction

endpackage

// ==== design/bscan_sync.sv ====
`timescale 1ns/1ps
module bscan_sync
    import bscan_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // Asynchronous in, synchronised out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s_reg;
    sync_state_t s_next;

    if (WIDTH < 1) begin : g_bad_width
        $error("bscan_sync needs WIDTH of at least one");
    end

    // First stage feeds only the second
    always_comb begin
        s_next        = s_reg;
        s_next.meta   = d;
        s_next.stable = s_reg.meta;
    end

    // Two flop chain
    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.stable;

endmodule

// ==== design/test_reset_flag_reg.sv ====
`timescale 1ns/1ps
module test_reset_flag_reg
    import bscan_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Events
    input  wire logic reset_forced,
    input  wire logic power_on,
    input  wire logic sw_clear,
    // Flag
    output logic      test_reset_flag
);

    typedef struct packed {
        logic flag;
    } flag_state_t;

    flag_state_t s_reg;
    flag_state_t s_next;

    // Set wins over any clear in the same cycle
    always_comb begin
        s_next = s_reg;
        if (reset_forced) begin
            s_next.flag = 1'b1;
        end else if (power_on || sw_clear) begin
            s_next.flag = 1'b0;
        end
    end

    // Flag register
    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign test_reset_flag = s_reg.flag;

    // Forced reset sets the flag next cycle
    property p_flag_set;
        @(posedge clk) disable iff (srst) reset_forced |=> test_reset_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("test reset flag not set after forced reset");

    // Flag only falls through power-on or software clear
    property p_flag_clear;
        @(posedge clk) disable iff (srst)
            $fell(test_reset_flag) |-> $past(power_on) || $past(sw_clear);
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("test reset flag cleared without a clearing event");

endmodule

// ==== design/boundary_scan_cells.sv ====
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module boundary_scan_cells
    import bscan_pkg::*;
(
    // System clock and reset
    input  wire logic                CLK,
    input  wire logic                SRST,
    // Scan link from the test controller, asynchronous
    input  wire logic                TCK,
    input  wire logic                TDI,
    input  wire tap_ctl_t            TAP_CTL,
    output logic                     TDO,
    // Port pins
    input  wire logic [NUM_PINS-1:0] PIN_IN,
    output logic      [NUM_PINS-1:0] PIN_OUT,
    output logic      [NUM_PINS-1:0] PIN_OE_N,
    output logic      [NUM_PINS-1:0] PIN_PULLUP_EN,
    // Port logic, same clock domain
    input  wire logic [NUM_PINS-1:0] PORT_OUTPUT_REGISTER,
    input  wire logic [NUM_PINS-1:0] DIRECTION_REGISTER_BIT,
    input  wire logic                GLOBAL_PULLUP_DISABLE,
    // Reset detectors, asynchronous
    input  wire logic                NORMAL_RESET_N,
    input  wire logic                HV_RESET,
    input  wire logic                POWER_ON_RESET,
    output logic                     TEST_RESET_OUT,
    // Clock sources
    input  wire clk_ctl_t            SYS_OSC_ENABLE,
    input  wire clk_ctl_t            CLOCK_LINE,
    output clk_ctl_t                 OSC_ENABLE,
    // Analog comparator boundary
    input  wire cmp_ctl_t            SYS_CMP_CTL,
    input  wire logic                COMPARATOR_OUTPUT,
    output cmp_ctl_t                 CMP_CTL,
    // Register port
    input  wire logic [ADDR_W-1:0]   REG_ADDR,
    input  wire logic [7:0]          REG_WDATA,
    input  wire logic                REG_WR,
    input  wire logic                REG_RD,
    output logic      [7:0]          REG_RDATA
);

    scan_state_t          s_reg;
    scan_state_t          s_next;
    async_in_t            raw_in;
    async_in_t            sy;
    logic [CHAIN_LEN-1:0] cap;
    logic                 tck_rise;
    logic                 bscan_sel;
    logic                 reset_forced;
    logic                 sw_clear;
    logic                 flag;
    logic                 pu_sys;
    logic                 oe_eff;
    clk_ctl_t             en_eff;
    cmp_ctl_t             cmp_eff;
    int                   b;

    // Gather asynchronous inputs into one bundle
    always_comb begin
        raw_in                = '0;
        raw_in.pin_in         = PIN_IN;
        raw_in.tck            = TCK;
        raw_in.tdi            = TDI;
        raw_in.tap            = TAP_CTL;
        raw_in.normal_reset_n = NORMAL_RESET_N;
        raw_in.hv_reset       = HV_RESET;
        raw_in.clk_line       = CLOCK_LINE;
        raw_in.cmp_out        = COMPARATOR_OUTPUT;
        raw_in.power_on       = POWER_ON_RESET;
    end

    // Two flop synchroniser for every outside input
    bscan_sync #(
        .WIDTH ($bits(async_in_t))
    ) u_sync (
        .clk  (CLK),
        .srst (SRST),
        .d    (raw_in),
        .q    (sy)
    );

    // Test clock edge and instruction decode
    assign tck_rise     = sy.tck & ~s_reg.tck_prev;
    assign bscan_sel    = sy.tap.extest | sy.tap.sample;
    assign reset_forced = s_reg.reset_bit & sy.tap.force_reset;
    assign sw_clear     = REG_WR && (REG_ADDR == STATUS_ADDR) && !REG_WDATA[TEST_RESET_BIT];

    // Status flag keeper
    test_reset_flag_reg u_flag (
        .clk             (CLK),
        .srst            (SRST),
        .reset_forced    (reset_forced),
        .power_on        (sy.power_on),
        .sw_clear        (sw_clear),
        .test_reset_flag (flag)
    );

    // Cell behaviour, output muxing and register reads
    always_comb begin
        s_next          = s_reg;
        cap             = '0;
        b               = 0;
        pu_sys          = 1'b0;
        oe_eff          = 1'b0;
        s_next.tck_prev = sy.tck;

        // Effective clock enables and comparator inputs
        if (sy.tap.extest) begin
            en_eff.ext    = s_reg.upd[POS_EXT_EN];
            en_eff.osc    = s_reg.upd[POS_OSC_EN];
            en_eff.lf     = s_reg.upd[POS_LF_EN];
            en_eff.timer  = s_reg.upd[POS_TIMER_EN];
            cmp_eff.idle    = s_reg.upd[POS_CMP_IDLE];
            cmp_eff.bandgap = s_reg.upd[POS_BG_EN];
        end else begin
            en_eff  = SYS_OSC_ENABLE;
            cmp_eff = SYS_CMP_CTL;
        end
        s_next.osc_en = en_eff;
        s_next.cmp    = cmp_eff;

        // Pin cells: pull-up cell plus two stage bidirectional cell
        for (int i = 0; i < NUM_PINS; i++) begin
            b      = pin_base(i);
            pu_sys = ~GLOBAL_PULLUP_DISABLE & ~DIRECTION_REGISTER_BIT[i]
                     & PORT_OUTPUT_REGISTER[i];
            if (sy.tap.extest) begin
                s_next.pin_out[i]  = s_reg.upd[b + PIN_DATA_OFS];
                s_next.pin_oe_n[i] = ~s_reg.upd[b + PIN_CTRL_OFS];
                s_next.pin_pu[i]   = s_reg.upd[b + PIN_PULLUP_OFS];
                oe_eff             = s_reg.upd[b + PIN_CTRL_OFS];
            end else begin
                s_next.pin_out[i]  = PORT_OUTPUT_REGISTER[i];
                s_next.pin_oe_n[i] = ~DIRECTION_REGISTER_BIT[i];
                s_next.pin_pu[i]   = pu_sys;
                oe_eff             = DIRECTION_REGISTER_BIT[i];
            end
            cap[b + PIN_DATA_OFS]   = sy.pin_in[i];
            cap[b + PIN_CTRL_OFS]   = oe_eff;
            cap[b + PIN_PULLUP_OFS] = sy.tap.extest ? s_reg.upd[b + PIN_PULLUP_OFS]
                                                    : pu_sys;
        end

        // Reset detectors, observe only
        cap[POS_RST_NORMAL] = sy.normal_reset_n;
        cap[POS_RST_HV]     = sy.hv_reset;

        // Clock enables and clock lines; an unused line reads zero
        cap[POS_EXT_EN]   = en_eff.ext;
        cap[POS_OSC_EN]   = en_eff.osc;
        cap[POS_LF_EN]    = en_eff.lf;
        cap[POS_TIMER_EN] = en_eff.timer;
        cap[POS_EXT_CK]   = sy.clk_line.ext & en_eff.ext;
        cap[POS_OSC_CK]   = sy.clk_line.osc & en_eff.osc;
        cap[POS_LF_CK]    = sy.clk_line.lf & en_eff.lf;
        cap[POS_TIMER_CK] = sy.clk_line.timer & en_eff.timer;

        // Comparator boundary at the top of the chain
        cap[POS_CMP_IDLE] = cmp_eff.idle;
        cap[POS_CMP_OUT]  = sy.cmp_out & ~cmp_eff.idle;
        cap[POS_BG_EN]    = cmp_eff.bandgap;

        // Chain actions on each test clock rising edge under external test or sample
        if (tck_rise && bscan_sel) begin
            if (sy.tap.capture) begin
                s_next.chain = cap;
            end else if (sy.tap.shift) begin
                s_next.chain = {sy.tdi, s_reg.chain[CHAIN_LEN-1:1]};
            end else if (sy.tap.update) begin
                s_next.upd = s_reg.chain;
            end
        end

        // One bit reset register, not latched
        if (tck_rise && sy.tap.force_reset && sy.tap.shift) begin
            s_next.reset_bit = sy.tdi;
        end
        s_next.test_reset = s_reg.reset_bit;

        // Serial output, least significant bit first
        s_next.tdo = sy.tap.force_reset ? s_reg.reset_bit : s_reg.chain[0];

        // Register read data for the cycle after the strobe
        if (REG_RD && (REG_ADDR == STATUS_ADDR)) begin
            s_next.rdata                 = STATUS_RESET;
            s_next.rdata[TEST_RESET_BIT] = flag;
        end else begin
            s_next.rdata = READ_UNMAPPED;
        end
    end

    // State register
    always_ff @(posedge CLK) begin
        if (SRST) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flops
    assign TDO            = s_reg.tdo;
    assign PIN_OUT        = s_reg.pin_out;
    assign PIN_OE_N       = s_reg.pin_oe_n;
    assign PIN_PULLUP_EN  = s_reg.pin_pu;
    assign OSC_ENABLE     = s_reg.osc_en;
    assign CMP_CTL        = s_reg.cmp;
    assign TEST_RESET_OUT = s_reg.test_reset;
    assign REG_RDATA      = s_reg.rdata;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    // Shift moves data toward bit zero with TDI entering at the top
    property p_shift_lsb;
        tck_rise && bscan_sel && !sy.tap.capture && sy.tap.shift |=>
            s_reg.chain == {$past(sy.tdi), $past(s_reg.chain[CHAIN_LEN-1:1])};
    endproperty
    a_shift_lsb: assert property (p_shift_lsb)
        else $error("chain did not shift least significant bit first");

    // Serial output follows chain bit zero one cycle later
    property p_tdo_lsb;
        !sy.tap.force_reset |=> TDO == $past(s_reg.chain[0]);
    endproperty
    a_tdo_lsb: assert property (p_tdo_lsb)
        else $error("serial output is not chain bit zero");

    // External test drives pin zero from its update latches
    property p_extest_drive;
        sy.tap.extest |=> PIN_OUT[0] == $past(s_reg.upd[PIN_DATA_OFS])
                          && PIN_OE_N[0] == !$past(s_reg.upd[PIN_CTRL_OFS]);
    endproperty
    a_extest_drive: assert property (p_extest_drive)
        else $error("pin zero not driven from its cell in external test");

    // Outside external test the port logic owns the pins
    property p_normal_pins;
        !sy.tap.extest |=> PIN_OUT == $past(PORT_OUTPUT_REGISTER)
                           && PIN_OE_N == ~$past(DIRECTION_REGISTER_BIT);
    endproperty
    a_normal_pins: assert property (p_normal_pins)
        else $error("pins not following port logic outside external test");

    // Capture takes the synchronised pin level and the pull-up term
    property p_capture_pin;
        tck_rise && bscan_sel && sy.tap.capture && !sy.tap.extest |=>
            s_reg.chain[PIN_DATA_OFS] == $past(sy.pin_in[0])
            && s_reg.chain[PIN_PULLUP_OFS] == $past(~GLOBAL_PULLUP_DISABLE
               & ~DIRECTION_REGISTER_BIT[0] & PORT_OUTPUT_REGISTER[0]);
    endproperty
    a_capture_pin: assert property (p_capture_pin)
        else $error("pin zero capture mismatch");

    // Unused external clock line captures as zero
    property p_clock_unused;
        tck_rise && bscan_sel && sy.tap.capture && !en_eff.ext |=>
            s_reg.chain[POS_EXT_CK] == 1'b0;
    endproperty
    a_clock_unused: assert property (p_clock_unused)
        else $error("unused clock line captured non-zero");

    // Idle comparator captures a zero output
    property p_cmp_idle;
        tck_rise && bscan_sel && sy.tap.capture && cmp_eff.idle |=>
            s_reg.chain[POS_CMP_OUT] == 1'b0;
    endproperty
    a_cmp_idle: assert property (p_cmp_idle)
        else $error("idle comparator output captured non-zero");

    // Reset detectors are observed on capture
    property p_reset_observe;
        tck_rise && bscan_sel && sy.tap.capture |=>
            s_reg.chain[POS_RST_NORMAL] == $past(sy.normal_reset_n)
            && s_reg.chain[POS_RST_HV] == $past(sy.hv_reset);
    endproperty
    a_reset_observe: assert property (p_reset_observe)
        else $error("reset detector not observed");

    // Update copies the chain and leaves it unchanged
    property p_update;
        tck_rise && bscan_sel && !sy.tap.capture && !sy.tap.shift && sy.tap.update |=>
            s_reg.upd == $past(s_reg.chain) && $stable(s_reg.chain);
    endproperty
    a_update: assert property (p_update)
        else $error("update did not latch the chain");

    // A one in the reset register asserts device reset one cycle on
    property p_force_reset;
        s_reg.reset_bit |=> TEST_RESET_OUT;
    endproperty
    a_force_reset: assert property (p_force_reset)
        else $error("reset request not asserted");

    // Pull-ups follow port logic outside external test
    property p_normal_pullup;
        !sy.tap.extest |=> PIN_PULLUP_EN == $past(~DIRECTION_REGISTER_BIT
            & PORT_OUTPUT_REGISTER & ~{NUM_PINS{GLOBAL_PULLUP_DISABLE}});
    endproperty
    a_normal_pullup: assert property (p_normal_pullup)
        else $error("pull-up enable mismatch");

    // Clock and comparator inputs pass through outside external test
    property p_normal_src;
        !sy.tap.extest |=> OSC_ENABLE == $past(SYS_OSC_ENABLE)
            && CMP_CTL == $past(SYS_CMP_CTL);
    endproperty
    a_normal_src: assert property (p_normal_src)
        else $error("system input mismatch");

    // Reset register is the serial path while selected
    property p_tdo_reset;
        sy.tap.force_reset |=>
            TDO == $past(s_reg.reset_bit);
    endproperty
    a_tdo_reset: assert property (p_tdo_reset)
        else $error("serial output is not the reset register");

    // Edges outside scan instructions leave the cells alone
    property p_refused;
        tck_rise && !bscan_sel |=>
            $stable(s_reg.chain) && $stable(s_reg.upd);
    endproperty
    a_refused: assert property (p_refused)
        else $error("cells moved outside a scan instruction");

    // Status read shows the flag in the cycle after the strobe
    property p_status_read;
        REG_RD && (REG_ADDR == STATUS_ADDR) |=>
            REG_RDATA == {3'h0, $past(flag), 4'h0};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read does not show the flag");

    // Main scenarios
    c_capture: cover property (tck_rise && sy.tap.extest && sy.tap.capture);
    c_update:  cover property (tck_rise && sy.tap.extest && sy.tap.update);
    c_forced:  cover property (reset_forced ##1 flag);
    c_clear:   cover property (flag ##1 sw_clear ##1 !flag);

endmodule

// ==== testbench/bscan_tester.sv ====
`timescale 1ns/1ps
module bscan_tester
    import bscan_pkg::*;
(
    // Scan link to the device
    output logic      tck,
    output logic      tdi,
    output tap_ctl_t  ctl,
    input  wire logic tdo
);
    // Link idles with its clock low
    initial begin
        tck = 1'b0;
        tdi = 1'b0;
        ctl = '0;
    end

    // One 125 ns period; TDO is taken just before the rising edge
    task automatic pulse(input logic d, output logic q);
        tdi <= d;
        #62.5;
        q = tdo;
        tck <= 1'b1;
        #62.5;
        tck <= 1'b0;
    endtask

    // Capture, shift n bits, update, then keep the mode selected
    task automatic scan(input tap_ctl_t m, input logic [CHAIN_LEN-1:0] din,
                        input int n, output logic [CHAIN_LEN-1:0] dout);
        logic q;
        dout = '0;
        ctl <= tap_ctl_t'(m | 6'h20);
        pulse(~tdi, q);
        ctl <= tap_ctl_t'(m | 6'h10);
        for (int i = 0; i < n; i++) begin
            pulse(din[i], q);
            dout[i] = q;
        end
        ctl <= tap_ctl_t'(m | 6'h08);
        pulse(~tdi, q);
        ctl <= m;
        tdi <= ~tdi; // Released data line does not keep its level
        #62.5; // Clock rests low before the next frame
    endtask
endmodule

// ==== testbench/tb_boundary_scan_cells.sv ====
`timescale 1ns/1ps
module tb_boundary_scan_cells
    import bscan_pkg::*;
;
    localparam tap_ctl_t SMP = 6'h02;
    localparam tap_ctl_t EXT = 6'h04;
    localparam tap_ctl_t FRC = 6'h01;
    logic                 CLK, SRST, TCK, TDI, TDO, POWER_ON_RESET, TEST_RESET_OUT;
    logic                 GLOBAL_PULLUP_DISABLE, NORMAL_RESET_N, HV_RESET, COMPARATOR_OUTPUT;
    logic                 REG_WR, REG_RD, e;
    tap_ctl_t             TAP_CTL;
    logic [NUM_PINS-1:0]  PIN_IN, PIN_OUT, PIN_OE_N, PIN_PULLUP_EN, pin_ext;
    logic [NUM_PINS-1:0]  PORT_OUTPUT_REGISTER, DIRECTION_REGISTER_BIT;
    clk_ctl_t             SYS_OSC_ENABLE, CLOCK_LINE, OSC_ENABLE;
    cmp_ctl_t             SYS_CMP_CTL, CMP_CTL;
    logic [7:0]           REG_ADDR, REG_WDATA, REG_RDATA;
    logic [CHAIN_LEN-1:0] dout, din;
    int                   bad_count, check_count, cyc;

    // Pin wire level from the device drive and the outside world
    assign PIN_IN = (PIN_OE_N & pin_ext) | (~PIN_OE_N & PIN_OUT);

    bscan_tester tst (.tck(TCK), .tdi(TDI), .ctl(TAP_CTL), .tdo(TDO));

    boundary_scan_cells i_dut (.CLK(CLK), .SRST(SRST), .TCK(TCK), .TDI(TDI),
        .TAP_CTL(TAP_CTL), .TDO(TDO), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
        .PIN_OE_N(PIN_OE_N), .PIN_PULLUP_EN(PIN_PULLUP_EN),
        .PORT_OUTPUT_REGISTER(PORT_OUTPUT_REGISTER),
        .DIRECTION_REGISTER_BIT(DIRECTION_REGISTER_BIT),
        .GLOBAL_PULLUP_DISABLE(GLOBAL_PULLUP_DISABLE), .NORMAL_RESET_N(NORMAL_RESET_N),
        .HV_RESET(HV_RESET), .POWER_ON_RESET(POWER_ON_RESET),
        .TEST_RESET_OUT(TEST_RESET_OUT), .SYS_OSC_ENABLE(SYS_OSC_ENABLE),
        .CLOCK_LINE(CLOCK_LINE), .OSC_ENABLE(OSC_ENABLE), .SYS_CMP_CTL(SYS_CMP_CTL),
        .COMPARATOR_OUTPUT(COMPARATOR_OUTPUT), .CMP_CTL(CMP_CTL), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));

    // System clock, 5 ns
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [7:0] s, input logic [7:0] x);
        check_count++;
        if (s !== x) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, x);
        end
    endtask

    // Register port: one-cycle strobes, read data in the next cycle only
    task automatic wr(input logic [7:0] d);
        @(posedge CLK);
        REG_ADDR <= STATUS_ADDR;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask

    task automatic rd_is(input logic [7:0] a, input logic [7:0] x);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1;
        chk(REG_RDATA, x);
    endtask

    initial begin
        SRST = 1'b1;
        {REG_WR, REG_RD, POWER_ON_RESET, cyc, bad_count, check_count} = '0;
        {REG_ADDR, REG_WDATA} = '0;
        {NORMAL_RESET_N, HV_RESET, GLOBAL_PULLUP_DISABLE, SYS_OSC_ENABLE} = 7'h40;
        {pin_ext, PORT_OUTPUT_REGISTER, DIRECTION_REGISTER_BIT} = '0;
        CLOCK_LINE = 4'hF;
        COMPARATOR_OUTPUT = 1'b1;
        SYS_CMP_CTL = 2'b10;
        repeat (8) @(posedge CLK);
        SRST <= 1'b0;
        rd_is(STATUS_ADDR, STATUS_RESET);
        rd_is(8'h35, READ_UNMAPPED);
        // Snapshot with two opposite input settings, one clock source each
        for (int k = 0; k < 2; k++) begin
            @(posedge CLK);
            e = k[0];
            NORMAL_RESET_N <= e;
            HV_RESET <= ~e;
            GLOBAL_PULLUP_DISABLE <= e;
            SYS_OSC_ENABLE <= e ? 4'b0001 : 4'b1000;
            pin_ext <= e ? 31'h2AAA5555 : 31'h5555AAAA;
            PORT_OUTPUT_REGISTER <= e ? 31'h33333333 : 31'h4CCCCCCC;
            DIRECTION_REGISTER_BIT <= e ? 31'h0F0F0F0F : 31'h70F0F0F0;
            tst.scan(SMP, '0, CHAIN_LEN, dout);
            for (int i = 0; i < NUM_PINS; i++) begin
                chk(dout[PIN_BASE[i] + PIN_DATA_OFS], DIRECTION_REGISTER_BIT[i] ?
                    PORT_OUTPUT_REGISTER[i] : pin_ext[i]);
                chk(dout[PIN_BASE[i] + PIN_CTRL_OFS], DIRECTION_REGISTER_BIT[i]);
                chk(dout[PIN_BASE[i]], {~GLOBAL_PULLUP_DISABLE & ~DIRECTION_REGISTER_BIT[i]
                    & PORT_OUTPUT_REGISTER[i]});
            end
            chk({dout[POS_RST_NORMAL], dout[POS_RST_HV]}, {e, ~e});
            chk({dout[POS_EXT_CK], dout[POS_OSC_CK], dout[POS_LF_CK]}, {~e, 2'b00});
            chk(dout[POS_TIMER_CK], e);
            chk(dout[POS_CMP_OUT], 1'b0);
        end
        // Drive pins, timer oscillator and comparator from the chain
        din = '0;
        din[2:0] = 3'b111;
        din[PIN_BASE[30] + PIN_CTRL_OFS] = 1'b1;
        din[POS_TIMER_EN] = 1'b1;
        din[POS_CMP_IDLE] = 1'b1;
        for (int k = 0; k < 2; k++) begin
            tst.scan(EXT, din, CHAIN_LEN, dout);
        end
        chk({dout[2], dout[PIN_BASE[30] + PIN_DATA_OFS]}, 2'b10);
        chk({PIN_OUT[0], PIN_OE_N[0], PIN_PULLUP_EN[0]}, 3'b101);
        chk({PIN_OE_N[1], PIN_OUT[30], PIN_OE_N[30]}, 3'b100);
        chk(OSC_ENABLE, 4'b0001);
        chk(CMP_CTL, 2'b10);
        // Forced reset sets the flag; only power-on or a written zero clears it
        tst.scan(FRC, 1, 1, dout);
        repeat (4) @(posedge CLK);
        chk(TEST_RESET_OUT, 1'b1);
        rd_is(STATUS_ADDR, 8'h10);
        wr(8'h00);
        rd_is(STATUS_ADDR, 8'h10);
        tst.scan(FRC, 0, 1, dout);
        chk({dout[0], TEST_RESET_OUT}, 2'b10);
        rd_is(STATUS_ADDR, 8'h10);
        @(posedge CLK);
        POWER_ON_RESET <= 1'b1;
        repeat (4) @(posedge CLK);
        POWER_ON_RESET <= 1'b0;
        rd_is(STATUS_ADDR, 8'h00);
        tst.scan(FRC, 1, 1, dout);
        tst.scan(FRC, 0, 1, dout);
        wr(8'hFF);
        rd_is(STATUS_ADDR, 8'h10);
        wr(8'h00);
        rd_is(STATUS_ADDR, 8'h00);
        report_and_stop();
    end
endmodule
